// *** rtl/eeprom_pkg.sv ***
/*
 * Shared constants, types and helper functions for the two-wire serial
 * memory slave: APB register map, field positions, reset values, link
 * states, memory size options and the internal write cycle count.
 * Assumes a 25 MHz system clock and 32-bit APB data.
 */
package eeprom_pkg;

    // memory size options, one per density of the family
    typedef enum logic [2:0] {
        SIZE_1K  = 3'h0,
        SIZE_2K  = 3'h1,
        SIZE_4K  = 3'h2,
        SIZE_8K  = 3'h3,
        SIZE_16K = 3'h4
    } mem_size_t;

    // receive and acknowledge states of the serial link
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_DEV      = 3'h1,
        ST_ACK_DEV  = 3'h2,
        ST_WADDR    = 3'h3,
        ST_ACK_ADDR = 3'h4,
        ST_DATA     = 3'h5,
        ST_ACK_DATA = 3'h6,
        ST_IGNORE   = 3'h7
    } link_state_t;

    // strapped select inputs, in device address word order
    typedef struct packed {
        logic select_pin_high;
        logic select_pin_mid;
        logic select_pin_low;
    } strap_t;

    // status register layout
    typedef struct packed {
        logic [27:0] zero;
        logic wp_level;
        logic transfer;
        logic standby;
        logic busy;
    } status_t;

    // array geometry at the largest size
    localparam int ADDR_W = 11;
    localparam int MEM_DEPTH = 2048;
    localparam int BUF_DEPTH = 16;

    // device address word fields
    localparam logic [3:0] DEV_TYPE = 4'h6; // arbitrary value
    localparam int DEVW_TYPE_LSB = 4;
    localparam int DEVW_SEL_LSB = 1;
    localparam int DEVW_RW_BIT = 0;

    // register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;
    localparam logic [7:0] REG_MEM_INDEX = 8'h0C;
    localparam logic [7:0] REG_MEM_DATA = 8'h10;

    // register fields and reset values
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_ENABLE_RST = 1'b1;
    localparam logic [10:0] MEM_INDEX_RST = 11'h000;

    // internal write cycle timing
    localparam int CLK_HZ = 25000000;
    localparam int INTERNAL_WRITE_TIME_MS = 5;
    localparam int WRITE_CYCLES = INTERNAL_WRITE_TIME_MS * (CLK_HZ / 1000);
    localparam int WCNT_W = 17;

    // select bits compared against the straps for each size
    function automatic logic [2:0] cmp_mask(input mem_size_t s);
        case (s)
            SIZE_1K, SIZE_2K: cmp_mask = 3'h7;
            SIZE_4K: cmp_mask = 3'h6;
            SIZE_8K: cmp_mask = 3'h4;
            default: cmp_mask = 3'h0;
        endcase
    endfunction

    // word address bits that exist for each size
    function automatic logic [10:0] addr_mask(input mem_size_t s);
        case (s)
            SIZE_1K: addr_mask = 11'h07F;
            SIZE_2K: addr_mask = 11'h0FF;
            SIZE_4K: addr_mask = 11'h1FF;
            SIZE_8K: addr_mask = 11'h3FF;
            default: addr_mask = 11'h7FF;
        endcase
    endfunction

    // in-page address bits for each size
    function automatic logic [3:0] page_mask(input mem_size_t s);
        case (s)
            SIZE_1K, SIZE_2K: page_mask = 4'h7;
            default: page_mask = 4'hF;
        endcase
    endfunction

endpackage

// *** rtl/bit_sync.sv ***
/*
 * Two flip-flop synchroniser for a bundle of slow, unrelated levels.
 * Assumes each bit is a static or slowly moving level; bits are not
 * guaranteed to arrive in the same cycle as each other.
 */
`timescale 1ns/10ps
`default_nettype none

module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end

endmodule // bit_sync

`default_nettype wire

// *** rtl/two_wire_eeprom_write_path.sv ***
/*
 * Two-wire serial memory slave, write path: start and stop detection,
 * device address compare against the straps, acknowledge, byte and page
 * writes with in-page wrap, and a self-timed write cycle during which the
 * device refuses to acknowledge. An APB slave gives software a view of
 * the array and the link state.
 * Assumes scl and sda are open-drain bus levels from another domain,
 * sampled by pclk well above the bus bit rate; the far end resolves the
 * sda wire from sda_oe.
 */
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - data changes only while scl is low; changes in scl high mark conditions
// - sda falling while scl high is a start, needed before any command
// - sda rising while scl high is a stop, returning to standby
// - every word is eight bits; device drives ack low in ninth clock
// - standby after reset and after stop once internal write ends
// - address word follows each start; top four bits hold type prefix
// - two smallest sizes compare three select bits with the straps
// - mid size compares upper two select bits; third is page bit
// - second largest compares top select bit; next two are page bits
// - largest compares none; page bits are the top word address bits
// - address word bit zero: high means read, low means write
// - match gives ack; mismatch returns to standby, ignoring the transfer (here it waits in ST_IGNORE until the next start or stop)
// - byte write: word address then data byte, both acknowledged
// - stop after a write starts a self-timed cycle, no response meanwhile
// - page holds eight bytes on two smallest sizes, else sixteen
// - page write sends up to seven or fifteen more acknowledged bytes
// - only the in-page address bits increment after each data byte
// - bytes past a page wrap round and overwrite earlier bytes
// - address polling during the write cycle gets ack only when done
// - sample incoming data on scl rise, change own drive on scl fall
// - write protect high blocks all writes; low allows normal operation
// - largest size uses eleven address bits, 128 pages of sixteen
module two_wire_eeprom_write_path #(
    parameter eeprom_pkg::mem_size_t MEM_SIZE = eeprom_pkg::SIZE_16K,
    parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire eeprom_pkg::strap_t straps,
    input wire logic write_protect
);
    import eeprom_pkg::*;

    logic scl_s, sda_s, scl_d, sda_d, wp_s;
    strap_t strap_s;
    logic scl_rise, scl_fall, start_det, stop_det;
    link_state_t state_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] rx_byte;
    logic ack_hi_r, rw_r;
    logic byte_done, dev_match;
    logic [2:0] dev_page_r;
    logic [10:0] addr_r, pm11;
    logic [3:0] pm;
    logic [BUF_DEPTH-1:0] valid_r;
    logic [7:0] page_buf [BUF_DEPTH];
    logic [7:0] mem [MEM_DEPTH];
    logic busy_r, commit_now, enable_r, rd_hit, got_data_r;
    logic [WCNT_W-1:0] wcnt_r;
    logic [10:0] mem_index_r;
    logic [31:0] rd_data;
    status_t status;

    // bring bus pins and straps into the pclk domain
    bit_sync #(.WIDTH(2)) u_link_sync (
        .clk(pclk), .rst_n(presetn),
        .din({scl_i, sda_i}),
        .dout({scl_s, sda_s})
    );

    bit_sync #(.WIDTH(4)) u_strap_sync (
        .clk(pclk), .rst_n(presetn),
        .din({straps, write_protect}),
        .dout({strap_s, wp_s})
    );

    // delayed copies of the synchronised levels for edge finding
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_d <= 1'b0;
            sda_d <= 1'b0;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // bus events; sda moving while scl stays high is a condition
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

    // size dependent masks
    assign pm = page_mask(MEM_SIZE);
    assign pm11 = {7'h00, pm};

    // byte assembly, sampled on the scl rise
    assign rx_byte = {shift_r[6:0], sda_s};
    assign byte_done = scl_rise && (bit_cnt_r == 3'h7) &&
        (state_r == ST_DEV || state_r == ST_WADDR || state_r == ST_DATA);

    // device address compare; a busy write cycle refuses every address
    assign dev_match = (rx_byte[DEVW_TYPE_LSB +: 4] == DEV_TYPE) &&
        (((rx_byte[DEVW_SEL_LSB +: 3] ^ strap_s) & cmp_mask(MEM_SIZE))
        == 3'h0) &&
        enable_r && !busy_r;

    // link sequencer: receive words, drive and release each acknowledge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 3'h0;
            shift_r <= 8'h00;
            ack_hi_r <= 1'b0;
            rw_r <= 1'b0;
            sda_oe <= 1'b0;
            sda_o <= 1'b0; // open drain: the device only ever pulls low
        end else if (start_det) begin
            state_r <= ST_DEV;
            bit_cnt_r <= 3'h0;
            ack_hi_r <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop_det) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 3'h0;
            sda_oe <= 1'b0;
        end else begin
            case (state_r)
                ST_DEV, ST_WADDR, ST_DATA: begin
                    if (scl_rise) begin
                        shift_r <= rx_byte;
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == 3'h7) begin
                            ack_hi_r <= 1'b0;
                            if (state_r == ST_DEV) begin
                                rw_r <= rx_byte[DEVW_RW_BIT];
                                state_r <= dev_match ? ST_ACK_DEV : ST_IGNORE;
                            end else if (state_r == ST_WADDR) begin
                                state_r <= ST_ACK_ADDR;
                            end else begin
                                state_r <= ST_ACK_DATA;
                            end
                        end
                    end
                end
                ST_ACK_DEV, ST_ACK_ADDR, ST_ACK_DATA: begin
                    if (scl_rise) begin
                        ack_hi_r <= 1'b1;
                    end else if (scl_fall && !ack_hi_r) begin
                        sda_oe <= 1'b1;
                    end else if (scl_fall) begin
                        sda_oe <= 1'b0;
                        if (state_r == ST_ACK_DEV) begin
                            // reads are not served: wait for the next condition
                            state_r <= rw_r ? ST_IGNORE : ST_WADDR;
                        end else begin
                            state_r <= ST_DATA;
                        end
                    end
                end
                ST_IDLE, ST_IGNORE: sda_oe <= 1'b0;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // word address and page tracking, frozen during the write cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dev_page_r <= 3'h0;
            addr_r <= 11'h000;
            valid_r <= '0;
            got_data_r <= 1'b0;
        end else if (busy_r) begin
            if (commit_now) begin
                valid_r <= '0;
                got_data_r <= 1'b0;
            end
        end else if (start_det || stop_det) begin
            got_data_r <= 1'b0;
        end else if (byte_done && state_r == ST_DEV) begin
            dev_page_r <= rx_byte[DEVW_SEL_LSB +: 3] & ~cmp_mask(MEM_SIZE);
        end else if (byte_done && state_r == ST_WADDR) begin
            addr_r <= {dev_page_r, rx_byte} & addr_mask(MEM_SIZE);
            valid_r <= '0;
        end else if (byte_done && state_r == ST_DATA) begin
            valid_r[addr_r[3:0] & pm] <= 1'b1;
            got_data_r <= 1'b1;
            addr_r <= (addr_r & ~pm11) |
                {7'h00, (addr_r[3:0] + 4'h1) & pm};
        end
    end

    // page latch; a wrapped page simply overwrites the earlier byte
    always_ff @(posedge pclk) begin
        if (!busy_r && byte_done && state_r == ST_DATA) begin
            page_buf[addr_r[3:0] & pm] <= rx_byte;
        end
    end

    // self-timed write cycle, started by the stop that ends a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
            wcnt_r <= '0;
        end else if (busy_r) begin
            if (wcnt_r == '0) begin
                busy_r <= 1'b0;
            end else begin
                wcnt_r <= wcnt_r - 1'b1;
            end
        end else if (stop_det && got_data_r && !wp_s) begin
            busy_r <= 1'b1;
            wcnt_r <= WCNT_W'(WRITE_CYCLES - 1);
        end
    end

    assign commit_now = busy_r && (wcnt_r == '0);

    // array update at the end of the cycle, only latched bytes change
    always_ff @(posedge pclk) begin
        if (commit_now) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                if (valid_r[i]) begin
                    mem[(addr_r & ~pm11) | ADDR_W'(i)] <= page_buf[i];
                end
            end
        end
    end

    // status word for software
    always_comb begin
        status = '0;
        status.busy = busy_r;
        status.standby = (state_r == ST_IDLE) && !busy_r;
        status.transfer = (state_r != ST_IDLE);
        status.wp_level = wp_s;
    end

    // APB read decode
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            REG_CTRL: rd_data = {31'h0000_0000, enable_r};
            REG_STATUS: rd_data = status;
            REG_ADDR: rd_data = {21'h00_0000, addr_r};
            REG_MEM_INDEX: rd_data = {21'h00_0000, mem_index_r};
            REG_MEM_DATA: rd_data = {24'h00_0000,
                mem[mem_index_r & addr_mask(MEM_SIZE)]};
            default: rd_hit = 1'b0;
        endcase
    end

    // APB slave: one wait state, then writes land on the pready edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            enable_r <= CTRL_ENABLE_RST;
            mem_index_r <= MEM_INDEX_RST;
        end else begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_data;
                pslverr <= !rd_hit;
            end
            if (psel && penable && pready && pwrite) begin
                case (paddr)
                    REG_CTRL: enable_r <= pwdata[CTRL_ENABLE_BIT];
                    REG_MEM_INDEX: mem_index_r <= pwdata[ADDR_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // checks on the link and write cycle
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_start_fresh;
        start_det |=> state_r == ST_DEV && bit_cnt_r == 3'h0 && !sda_oe;
    endproperty
    a_start_fresh: assert property (p_start_fresh)
        else $error("start did not restart address reception");
    property p_stop_idle;
        stop_det |=> state_r == ST_IDLE && !sda_oe;
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("stop did not return link to idle");
    property p_drive_low_phase;
        $rose(sda_oe) |-> !scl_d && !scl_s;
    endproperty
    a_drive_low_phase: assert property (p_drive_low_phase)
        else $error("sda drive changed while scl high");
    property p_ack_only;
        sda_oe |-> state_r inside {ST_ACK_DEV, ST_ACK_ADDR, ST_ACK_DATA};
    endproperty
    a_ack_only: assert property (p_ack_only)
        else $error("sda driven outside an acknowledge");
    property p_release;
        (state_r inside {ST_ACK_DEV, ST_ACK_ADDR, ST_ACK_DATA}) &&
            ack_hi_r && scl_fall |=> !sda_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("sda not released after ninth clock");
    property p_nomatch;
        byte_done && state_r == ST_DEV && !dev_match |=>
            state_r == ST_IGNORE ##1 !sda_oe;
    endproperty
    a_nomatch: assert property (p_nomatch)
        else $error("mismatched address was not ignored");
    property p_poll_refused;
        busy_r |-> state_r != ST_ACK_DEV;
    endproperty
    a_poll_refused: assert property (p_poll_refused)
        else $error("address acknowledged during write cycle");
    property p_cycle_start;
        stop_det && got_data_r && !wp_s && !busy_r |=>
            busy_r && wcnt_r == WCNT_W'(WRITE_CYCLES - 1);
    endproperty
    a_cycle_start: assert property (p_cycle_start)
        else $error("write cycle did not start with full count");
    property p_protect;
        stop_det && wp_s && !busy_r |=> !busy_r;
    endproperty
    a_protect: assert property (p_protect)
        else $error("write cycle started while protected");
    property p_wrap;
        byte_done && state_r == ST_DATA && !busy_r |=>
            ((addr_r ^ $past(addr_r)) & ~pm11) == 11'h000 &&
            (addr_r[3:0] & pm) == (($past(addr_r[3:0]) + 4'h1) & pm);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("page address did not wrap within page");

    c_byte_acked: cover property (state_r == ST_ACK_DATA && sda_oe);
    c_cycle: cover property ($rose(busy_r));
    c_poll: cover property (busy_r && byte_done && state_r == ST_DEV);
    c_read_ack: cover property (state_r == ST_ACK_DEV && rw_r && sda_oe);

endmodule // two_wire_eeprom_write_path

`default_nettype wire

// *** tb/two_wire_ctrl_model.sv ***
/*
 * Behavioural bus controller that drives the serial clock and pulls the
 * data line low, with start, stop, byte and recovery sequences.
 * Assumes the bench resolves the data wire with a pull-up and feeds it back.
 */
`timescale 1ns/10ps
`default_nettype none

module two_wire_ctrl_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda_wire
);
    // clock stands high and data is released between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // start: data falls while the clock is high, also as a repeated start
    task automatic start();
        sda_low = 1'b0;
        #160;
        scl = 1'b1;
        #80;
        sda_low = 1'b1;
        #160;
        scl = 1'b0;
    endtask

    // stop: data rises while the clock is high
    task automatic stop();
        sda_low = 1'b1;
        #160;
        scl = 1'b1;
        #80;
        sda_low = 1'b0;
        #160;
    endtask

    // eight bits msb first, then release and sample the ninth bit
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #80;
            sda_low = ~b[i];
            #80;
            scl = 1'b1;
            #160;
            scl = 1'b0;
        end
        #80;
        sda_low = 1'b0;
        #80;
        scl = 1'b1;
        #80;
        ack = ~sda_wire;
        #80;
        scl = 1'b0;
    endtask

    // nine clocks with data released to flush a stuck transfer
    task automatic recover(output logic hi);
        hi = 1'b1;
        repeat (9) begin
            scl = 1'b0;
            #160;
            scl = 1'b1;
            #80;
            hi = hi & sda_wire; // data must read high in every high phase
            #80;
        end
    endtask
endmodule // two_wire_ctrl_model

`default_nettype wire

// *** tb/two_wire_eeprom_write_path_tb_top.sv ***
/*
 * Self-checking bench: APB register checks and serial write frames.
 * Assumes the largest size and a shortened write cycle of 200 clocks.
 */
`timescale 1ns/10ps
`default_nettype none

module two_wire_eeprom_write_path_tb_top;
    import eeprom_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic scl, sda_wire, sda_o, sda_oe, ctl_low, write_protect, ack;
    logic sda_o_b, sda_oe_b;
    int failures, cmp_count;

    // open-drain wire with pull-up
    assign sda_wire = ~(ctl_low | (sda_oe & ~sda_o) | (sda_oe_b & ~sda_o_b));
    always #20 pclk = ~pclk;

    two_wire_eeprom_write_path #(.WRITE_CYCLES(200)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_i(scl), .sda_i(sda_wire),
        .sda_o(sda_o), .sda_oe(sda_oe), .straps(strap_t'(3'h5)),
        .write_protect(write_protect));
    // smallest size on the same wire, select pins strapped to 010
    two_wire_eeprom_write_path #(.MEM_SIZE(SIZE_1K), .WRITE_CYCLES(200))
        small_u (
        .pclk(pclk), .presetn(presetn), .psel(1'b0), .penable(1'b0),
        .pwrite(1'b0), .paddr(8'h00), .pwdata(32'h0), .prdata(),
        .pready(), .pslverr(), .scl_i(scl), .sda_i(sda_wire),
        .sda_o(sda_o_b), .sda_oe(sda_oe_b), .straps(strap_t'(3'h2)),
        .write_protect(write_protect));
    two_wire_ctrl_model ctl_u (.scl(scl), .sda_low(ctl_low),
        .sda_wire(sda_wire));

    // verdict and end of run
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask

    // one APB transfer, waiting for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            failures++;
            stop_test();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(nm, e, r);
    endtask

    task automatic mem(input logic [10:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, REG_MEM_INDEX, {21'h0, a}, r);
        rd(REG_MEM_DATA, {24'h0, d}, "mem data");
    endtask

    // poll status until the write cycle ends
    task automatic wait_idle();
        logic [31:0] r;
        int n;
        n = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0, r);
            n++;
        end while (r[0] !== 1'b0 && n < 100);
        if (n >= 100) begin
            failures++;
            stop_test();
        end
    endtask

    // full frame: address word, optional word address and n data bytes
    task automatic frame(input logic [7:0] dev, input logic [7:0] wa,
                         input int n, input logic [7:0] d0,
                         input logic ea);
        logic a;
        @(negedge pclk); // link edges stay clear of the sampling edge
        ctl_u.start();
        ctl_u.send_byte(dev, a);
        chk("dev ack", {31'h0, ea}, {31'h0, a});
        if (ea && n > 0) begin
            ctl_u.send_byte(wa, a);
            chk("addr ack", 32'h1, {31'h0, a});
            for (int i = 0; i < n; i++) begin
                ctl_u.send_byte(d0 + 8'(i), a);
                chk("data ack", 32'h1, {31'h0, a});
            end
        end
        ctl_u.stop();
    endtask

    // main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, write_protect} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        failures = 0;
        cmp_count = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(REG_STATUS, 32'h2, "status");
        rd(REG_CTRL, 32'h1, "ctrl");
        rd(REG_MEM_INDEX, 32'h0, "mem index");
        apb(1'b0, 8'h14, 32'h0, q);
        chk("unmapped data", 32'h0, q);
        chk("unmapped err", 32'h1, {31'h0, err});
        $display("test registers done");
        @(negedge pclk);
        ctl_u.recover(ack);
        chk("recover sda", 32'h1, {31'h0, ack});
        frame(8'h70, 8'h00, 0, 8'h00, 1'b0);
        frame(8'h61, 8'h00, 0, 8'h00, 1'b1);
        apb(1'b1, REG_CTRL, 32'h0, q);
        frame(8'h60, 8'h00, 0, 8'h00, 1'b0);
        frame(8'h64, 8'h00, 0, 8'h00, 1'b1);
        frame(8'h66, 8'h00, 0, 8'h00, 1'b0);
        apb(1'b1, REG_CTRL, 32'h1, q);
        $display("test addressing done");
        frame(8'h6A, 8'h3C, 1, 8'h40, 1'b1);
        rd(REG_STATUS, 32'h1, "status busy");
        frame(8'h60, 8'h00, 0, 8'h00, 1'b0);
        wait_idle();
        mem(11'h53C, 8'h40);
        rd(REG_ADDR, 32'h53D, "word addr");
        $display("test byte write done");
        frame(8'h60, 8'h0F, 17, 8'h40, 1'b1);
        wait_idle();
        mem(11'h000, 8'h41);
        mem(11'h00F, 8'h50);
        $display("test page wrap done");
        @(negedge pclk);
        ctl_u.start();
        ctl_u.send_byte(8'h60, ack);
        chk("dev ack", 32'h1, {31'h0, ack});
        ctl_u.send_byte(8'h05, ack);
        chk("addr ack", 32'h1, {31'h0, ack});
        rd(REG_STATUS, 32'h4, "status transfer");
        frame(8'h60, 8'h20, 1, 8'h40, 1'b1);
        wait_idle();
        mem(11'h020, 8'h40);
        $display("test restart done");
        @(posedge pclk);
        write_protect <= 1'b1;
        frame(8'h60, 8'h20, 1, 8'h77, 1'b1);
        rd(REG_STATUS, 32'hA, "status protect");
        mem(11'h020, 8'h40);
        $display("test protect done");
        stop_test();
    end
endmodule // two_wire_eeprom_write_path_tb_top

`default_nettype wire
